// File: rsc_pkg.sv
// Purpose: Constants and types shared by the reset strap capture block.
// Assumes: 100 MHz system clock, 16-bit register data, word addresses.
// Notes:   Register offsets are word indices on the plain register port.
package rsc_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_P01   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS_P23   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STRAP_WORD   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_FRAME_CLK_DLY = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DB_CLK_DLY   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CPU_STRAP    = 4'h5;

  // Status register layout
  localparam int STAT_INIT_DONE_BIT = 7;

  // Strap word bit positions
  localparam int SB_LINK_POL   = 0;
  localparam int SB_PWR_SAVE   = 1;
  localparam int SB_RSVD_A     = 2;
  localparam int SB_HOTPLUG_N  = 3;
  localparam int SB_RSVD_B     = 4;
  localparam int SB_DB_256K    = 5;
  localparam int SB_CPU_16BIT  = 6;
  localparam int SB_ONE_LAYER  = 7;
  localparam int SB_EEPROM_N   = 8;
  localparam int SB_MCT_AGE    = 9;
  localparam int SB_FCB_AGE    = 10;
  localparam int SB_TIMEOUT    = 11;
  localparam int SB_CPU_N      = 14;
  localparam int SB_RUN_NORMAL = 15;

  // CPU data strap fields
  localparam int CPU_STRAP_W   = 9;
  localparam int FRAME_DLY_LSB = 0;
  localparam int DB_DLY_LSB    = 6;
  localparam int DLY_W         = 3;
  localparam logic [DLY_W-1:0] DLY_BY_REG  = 3'h0;
  localparam logic [DLY_W-1:0] DLY_REG_RST = 3'h0;
  localparam logic [DLY_W-1:0] DLY_ONE     = 3'h1;

  // Frame memory size codes
  localparam logic [1:0] FSZ_512K = 2'h0;
  localparam logic [1:0] FSZ_1M   = 2'h1;
  localparam logic [1:0] FSZ_2M   = 2'h2;

  // Watchdog timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned WD_SECONDS  = 5;
  localparam int unsigned WD_CYCLES   = WD_SECONDS * CLK_HZ;
  localparam int          WD_CNT_W    = 32;

  typedef enum logic [1:0] {
    RSC_MODE_MII     = 2'b00,
    RSC_MODE_INVALID = 2'b01,
    RSC_MODE_GMII    = 2'b10,
    RSC_MODE_PCS     = 2'b11
  } rsc_port_mode_t;

endpackage

// File: rsc_strap_capture.sv
// Purpose: Samples the board straps at reset, decodes the configuration,
//          hands the shared pins back to the LED interface afterwards.
// Assumes: Straps are stable while reset is held and some cycles before.
// Notes:   Capture happens on the first clock edge after reset release.
//
// How it works
// R1: Straps are pulled-up inputs during reset
// R2: After reset, LED interface drives strap pins
// R3: Blink strap: 1 no blink, 0 blink
// R4: Select strap: 1 parallel, 0 serial LEDs
// R5: Per-port mode from enable and error straps
// R6: Bit 0 sets link-active polarity
// R7: Bit 1 enables MAC clock power saving
// R8: Board keeps reserved bits 2, 4 low
// R9: Bit 3 low enables module detection
// R10: Bit 5 sizes database SRAM
// R11: Bit 6 sets CPU bus width
// R12: Bit 7 sets frame memory layers
// R13: Top address straps size frame memory
// R14: Bit 8 low means EEPROM present
// R15: Bit 9 enables multicast table aging
// R16: Bit 10 enables buffer handle aging
// R17: Bit 11 enables five-second watchdog reset
// R18: Bit 14 low means CPU present
// R19: Bit 15 low loops memory self-test
// R20: Frame clock delay from CPU bits 2:0
// R21: Database clock delay from CPU bits 8:6
// R22: CPU pins returned after reset, 5:3 unused
// R23: Port modes readable with init-done bit
// R24: Latch straps once, hold until reset
`timescale 1ns/1ps
`default_nettype none

module rsc_strap_capture #(
  parameter int unsigned WD_LIMIT = rsc_pkg::WD_CYCLES
) (
  // Clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         sys_rst_i,
  // Shared LED data / strap pins
  input  wire logic [15:0]                  strap_pin_i,
  output logic      [15:0]                  strap_pin_o,
  output logic      [15:0]                  strap_pin_oe_o,
  output logic                              strap_pullup_en_o,
  // Blink strap / serial data pin
  input  wire logic                         blink_pin_i,
  output logic                              blink_pin_o,
  output logic                              blink_pin_oe_o,
  // Interface-select strap / envelope pin
  input  wire logic                         led_iface_select_strap_i,
  output logic                              serial_led_envelope_n_o,
  output logic                              envelope_pin_oe_o,
  // Other strap pins
  input  wire logic [3:0]                   port_txen_strap_i,
  input  wire logic [3:0]                   port_txerr_strap_i,
  input  wire logic                         frame_bank_top_addr_i,
  input  wire logic                         second_bank_top_addr_i,
  input  wire logic [rsc_pkg::CPU_STRAP_W-1:0] cpu_data_pin_i,
  // LED interface source after reset
  input  wire logic [15:0]                  parallel_led_bits_i,
  input  wire logic                         serial_led_data_i,
  input  wire logic                         serial_led_envelope_n_i,
  // Watchdog activity
  input  wire logic                         sm_busy_i,
  output logic                              wd_reset_o,
  // Decoded configuration
  output logic                              cfg_valid_o,
  output logic [7:0]                        port_mode_o,
  output logic                              led_blink_en_o,
  output logic                              led_parallel_o,
  output logic                              link_active_high_o,
  output logic                              power_save_en_o,
  output logic                              module_detect_en_o,
  output logic                              db_sram_256k_o,
  output logic                              cpu_bus_16bit_o,
  output logic                              frame_single_layer_o,
  output logic [1:0]                        frame_mem_size_o,
  output logic                              eeprom_present_o,
  output logic                              mct_aging_en_o,
  output logic                              fcb_aging_en_o,
  output logic                              timeout_reset_en_o,
  output logic                              cpu_present_o,
  output logic                              mem_selftest_loop_o,
  output logic [rsc_pkg::DLY_W-1:0]         frame_clk_delay_o,
  output logic [rsc_pkg::DLY_W-1:0]         db_clk_delay_o,
  // Register port
  input  wire logic [rsc_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [rsc_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [rsc_pkg::DATA_W-1:0]   reg_rdata_o
);
  import rsc_pkg::*;

  if (WD_LIMIT < 2) begin : g_chk
    $error("WD_LIMIT must be at least 2");
  end

  localparam int PIN_W = 16 + 1 + 1 + 4 + 4 + 2 + CPU_STRAP_W;
  localparam logic [WD_CNT_W-1:0] WD_LAST = WD_CNT_W'(WD_LIMIT - 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, no reset: they must follow the pins during reset
  logic [PIN_W-1:0] pins_all;
  logic [PIN_W-1:0] pins_s1;
  logic [PIN_W-1:0] pins_s2;

  assign pins_all = {cpu_data_pin_i, second_bank_top_addr_i, frame_bank_top_addr_i,
                     port_txerr_strap_i, port_txen_strap_i,
                     led_iface_select_strap_i, blink_pin_i, strap_pin_i};

  always_ff @(posedge clock_i) begin
    pins_s1 <= pins_all; // R1
    pins_s2 <= pins_s1;
  end

  wire logic [15:0]            s_strap  = pins_s2[15:0];
  wire logic                   s_blink  = pins_s2[16];
  wire logic                   s_select = pins_s2[17];
  wire logic [3:0]             s_txen   = pins_s2[21:18];
  wire logic [3:0]             s_txerr  = pins_s2[25:22];
  wire logic                   s_atop   = pins_s2[26];
  wire logic                   s_btop   = pins_s2[27];
  wire logic [CPU_STRAP_W-1:0] s_cpu    = pins_s2[PIN_W-1:28];

  ////////////////////////////////////////////////////////////////////////
  // Capture: one shot on the first edge after release
  logic                   cap_done;
  logic [15:0]            cfg_strap;
  logic [CPU_STRAP_W-1:0] cfg_cpu;
  wire  logic             cap_now = !cap_done;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_done  <= 1'b0;
      cfg_strap <= '1;
      cfg_cpu   <= '1;
    end else if (cap_now) begin
      cap_done  <= 1'b1;  // R24
      cfg_strap <= s_strap;
      cfg_cpu   <= s_cpu; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin ownership
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_pin_oe_o          <= '0;
      strap_pullup_en_o       <= 1'b1; // R1
      blink_pin_oe_o          <= 1'b0;
      envelope_pin_oe_o       <= 1'b0;
      strap_pin_o             <= '0;
      blink_pin_o             <= 1'b0;
      serial_led_envelope_n_o <= 1'b1;
    end else begin
      strap_pin_oe_o          <= '1;   // R2
      strap_pullup_en_o       <= 1'b0;
      blink_pin_oe_o          <= 1'b1; // R3
      envelope_pin_oe_o       <= 1'b1; // R4
      strap_pin_o             <= parallel_led_bits_i;
      blink_pin_o             <= serial_led_data_i;
      serial_led_envelope_n_o <= serial_led_envelope_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap decode
  logic [7:0] next_port_mode;
  for (genvar p = 0; p < 4; p++) begin : g_port
    assign next_port_mode[2*p +: 2] = {s_txen[p], s_txerr[p]}; // R5
  end

  wire logic [1:0] next_fsz = !s_atop ? FSZ_512K :
                              (s_btop ? FSZ_2M : FSZ_1M); // R13

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_valid_o          <= 1'b0;
      port_mode_o          <= {4{RSC_MODE_PCS}};
      led_blink_en_o       <= 1'b0;
      led_parallel_o       <= 1'b1;
      link_active_high_o   <= 1'b1;
      power_save_en_o      <= 1'b1;
      module_detect_en_o   <= 1'b0;
      db_sram_256k_o       <= 1'b1;
      cpu_bus_16bit_o      <= 1'b1;
      frame_single_layer_o <= 1'b1;
      frame_mem_size_o     <= FSZ_2M;
      eeprom_present_o     <= 1'b0;
      mct_aging_en_o       <= 1'b1;
      fcb_aging_en_o       <= 1'b1;
      timeout_reset_en_o   <= 1'b1;
      cpu_present_o        <= 1'b0;
      mem_selftest_loop_o  <= 1'b0;
    end else if (cap_now) begin
      cfg_valid_o          <= 1'b1;
      port_mode_o          <= next_port_mode;              // R5
      led_blink_en_o       <= !s_blink;                    // R3
      led_parallel_o       <= s_select;                    // R4
      link_active_high_o   <= s_strap[SB_LINK_POL];        // R6
      power_save_en_o      <= s_strap[SB_PWR_SAVE];        // R7
      module_detect_en_o   <= !s_strap[SB_HOTPLUG_N];      // R9
      db_sram_256k_o       <= s_strap[SB_DB_256K];         // R10
      cpu_bus_16bit_o      <= s_strap[SB_CPU_16BIT];       // R11
      frame_single_layer_o <= s_strap[SB_ONE_LAYER];       // R12
      frame_mem_size_o     <= next_fsz;                    // R13
      eeprom_present_o     <= !s_strap[SB_EEPROM_N];       // R14
      mct_aging_en_o       <= s_strap[SB_MCT_AGE];         // R15
      fcb_aging_en_o       <= s_strap[SB_FCB_AGE];         // R16
      timeout_reset_en_o   <= s_strap[SB_TIMEOUT];         // R17
      cpu_present_o        <= !s_strap[SB_CPU_N];          // R18
      mem_selftest_loop_o  <= !s_strap[SB_RUN_NORMAL];     // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory clock delay selection; software field used only for code 000
  logic [DLY_W-1:0] frame_clk_delay_reg;
  logic [DLY_W-1:0] db_clk_delay_reg;

  wire logic [DLY_W-1:0] frame_code = cfg_cpu[FRAME_DLY_LSB +: DLY_W];
  wire logic [DLY_W-1:0] db_code    = cfg_cpu[DB_DLY_LSB +: DLY_W];
  // Method is code minus one; 111 gives method 6, the normal choice
  wire logic [DLY_W-1:0] next_frame_dly = (frame_code == DLY_BY_REG) ?
                                          frame_clk_delay_reg : frame_code - DLY_ONE; // R20
  wire logic [DLY_W-1:0] next_db_dly    = (db_code == DLY_BY_REG) ?
                                          db_clk_delay_reg : db_code - DLY_ONE;       // R21

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_clk_delay_o <= DLY_REG_RST;
      db_clk_delay_o    <= DLY_REG_RST;
    end else begin
      frame_clk_delay_o <= next_frame_dly;
      db_clk_delay_o    <= next_db_dly;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: counts while any state machine is away from idle
  logic [WD_CNT_W-1:0] wd_count;
  wire  logic          wd_armed  = timeout_reset_en_o && cfg_valid_o && sm_busy_i;
  wire  logic          wd_expire = wd_armed && (wd_count == WD_LAST);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_count   <= '0;
      wd_reset_o <= 1'b0;
    end else begin
      wd_reset_o <= wd_expire; // R17
      if (!wd_armed || wd_expire) begin
        wd_count <= '0;
      end else begin
        wd_count <= wd_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port
  wire logic wr_frame_dly = reg_wr_i && (reg_addr_i == OFS_FRAME_CLK_DLY);
  wire logic wr_db_dly    = reg_wr_i && (reg_addr_i == OFS_DB_CLK_DLY);

  logic [DATA_W-1:0] stat_p01;
  logic [DATA_W-1:0] stat_p23;
  always_comb begin
    stat_p01 = '0;
    stat_p23 = '0;
    stat_p01[3:0] = port_mode_o[3:0]; // R23
    stat_p23[3:0] = port_mode_o[7:4];
    stat_p01[STAT_INIT_DONE_BIT] = cfg_valid_o;
    stat_p23[STAT_INIT_DONE_BIT] = cfg_valid_o;
  end

  wire logic [DATA_W-1:0] rd_mux =
    (reg_addr_i == OFS_STATUS_P01)    ? stat_p01 :
    (reg_addr_i == OFS_STATUS_P23)    ? stat_p23 :
    (reg_addr_i == OFS_STRAP_WORD)    ? cfg_strap :
    (reg_addr_i == OFS_FRAME_CLK_DLY) ? DATA_W'(frame_clk_delay_reg) :
    (reg_addr_i == OFS_DB_CLK_DLY)    ? DATA_W'(db_clk_delay_reg) :
    (reg_addr_i == OFS_CPU_STRAP)     ? DATA_W'(cfg_cpu) : '0;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_clk_delay_reg <= DLY_REG_RST;
      db_clk_delay_reg    <= DLY_REG_RST;
      reg_rdata_o         <= '0;
    end else begin
      if (wr_frame_dly) begin
        frame_clk_delay_reg <= reg_wdata_i[DLY_W-1:0];
      end
      if (wr_db_dly) begin
        db_clk_delay_reg <= reg_wdata_i[DLY_W-1:0];
      end
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence capture_edge_s;
    $rose(cap_done);
  endsequence

  pins_released_a: assert property (cap_done |=> (strap_pin_oe_o == '1) && blink_pin_oe_o // R2
    && !strap_pullup_en_o) else $error("Strap pins not handed to LED interface");

  cfg_frozen_a: assert property (cap_done && $past(cap_done) |-> $stable(cfg_strap) // R24
    && $stable(port_mode_o) && $stable(cfg_cpu)) else $error("Latched straps changed");

  blink_decode_a: assert property (capture_edge_s |-> led_blink_en_o == !$past(s_blink) // R3
    && led_parallel_o == $past(s_select)) else $error("LED strap decode wrong");

  port_mode_a: assert property (capture_edge_s |-> port_mode_o[1:0] == // R5
    {$past(s_txen[0]), $past(s_txerr[0])}) else $error("Port mode decode wrong");

  strap_bits_a: assert property (capture_edge_s |-> link_active_high_o == cfg_strap[0] // R6
    && module_detect_en_o == !cfg_strap[3] && eeprom_present_o == !cfg_strap[8]
    && cpu_present_o == !cfg_strap[14] && mem_selftest_loop_o == !cfg_strap[15])
    else $error("Strap word decode wrong");

  mem_size_a: assert property (capture_edge_s and !$past(s_atop) |-> // R13
    frame_mem_size_o == FSZ_512K) else $error("Frame memory size decode wrong");

  mem_size_big_a: assert property (capture_edge_s and $past(s_atop) |-> // R13
    frame_mem_size_o == ($past(s_btop) ? FSZ_2M : FSZ_1M))
    else $error("Frame memory size decode wrong");

  strap_more_a: assert property (capture_edge_s |-> // R7
    power_save_en_o == $past(s_strap[SB_PWR_SAVE]) && db_sram_256k_o == $past(s_strap[SB_DB_256K])
    && cpu_bus_16bit_o == $past(s_strap[SB_CPU_16BIT]) && mct_aging_en_o == $past(s_strap[SB_MCT_AGE])
    && frame_single_layer_o == $past(s_strap[SB_ONE_LAYER]) && fcb_aging_en_o == $past(s_strap[SB_FCB_AGE])
    && timeout_reset_en_o == $past(s_strap[SB_TIMEOUT])) else $error("Strap word decode wrong");

  cpu_latch_a: assert property (capture_edge_s |-> cfg_cpu == $past(s_cpu) // R22
    && cfg_strap == $past(s_strap)) else $error("Latched straps wrong");

  frame_delay_a: assert property (cap_done && frame_code != DLY_BY_REG |=> // R20
    frame_clk_delay_o == $past(frame_code) - DLY_ONE) else $error("Frame delay wrong");

  frame_delay_reg_a: assert property (cap_done && frame_code == DLY_BY_REG |=> // R20
    frame_clk_delay_o == $past(frame_clk_delay_reg)) else $error("Frame delay wrong");

  db_delay_a: assert property (cap_done && db_code != DLY_BY_REG |=> // R21
    db_clk_delay_o == $past(db_code) - DLY_ONE) else $error("Database delay wrong");

  db_delay_reg_a: assert property (cap_done && db_code == DLY_BY_REG |=> // R21
    db_clk_delay_o == $past(db_clk_delay_reg)) else $error("Database delay wrong");

  watchdog_fire_a: assert property (wd_armed && wd_count == WD_LAST |=> wd_reset_o // R17
    ##1 !wd_reset_o) else $error("Watchdog reset not a single pulse");

  wd_idle_a: assert property (!wd_armed |=> wd_count == '0 && !wd_reset_o) // R17
    else $error("Watchdog counted while idle");

  led_follow_a: assert property (cap_done |-> strap_pin_o == $past(parallel_led_bits_i) // R2
    && blink_pin_o == $past(serial_led_data_i)
    && serial_led_envelope_n_o == $past(serial_led_envelope_n_i)) else $error("LED pins stale");

  status_read_a: assert property (reg_rd_i && reg_addr_i == OFS_STATUS_P01 |=> // R23
    reg_rdata_o[STAT_INIT_DONE_BIT] == $past(cfg_valid_o)
    && reg_rdata_o[1:0] == $past(port_mode_o[1:0])) else $error("Status read wrong");

  status_p23_a: assert property (reg_rd_i && reg_addr_i == OFS_STATUS_P23 |=> // R23
    reg_rdata_o[STAT_INIT_DONE_BIT] == $past(cfg_valid_o)
    && reg_rdata_o[3:0] == $past(port_mode_o[7:4])) else $error("Status read wrong");

  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == '0) // R23
    else $error("Read data not cleared");

endmodule

`default_nettype wire

// File: rsc_strap_board.sv
// Purpose: Board strap resistors and pin resolution around the strap block.
// Assumes: One strap resistor per pin, pulled low where the mask bit is set.
// Notes:   Bits 15:0 shared LED pins, 16 blink pin, 17 select pin.
`timescale 1ns/1ps
`default_nettype none

module rsc_strap_board (
  // Clock
  input  wire logic        clock_i,
  // Board straps and device pin drivers
  input  wire logic [17:0] strap_low_i,
  input  wire logic [17:0] drv_i,
  input  wire logic [17:0] oe_i,
  input  wire logic        pullup_en_i,
  // Resolved pin levels
  output logic      [17:0] pin_o
);
  logic [17:0] low_mask;
  logic [17:0] last_q;

  // Reserved straps are never left to float high
  assign low_mask = strap_low_i | 18'h00014;

  always_comb begin
    for (int b = 0; b < 18; b++) begin
      if (oe_i[b]) pin_o[b] = drv_i[b];
      else if (low_mask[b]) pin_o[b] = 1'b0;
      else if (pullup_en_i) pin_o[b] = 1'b1;
      // Floating pin: no stale level for the simulator to keep
      else pin_o[b] = ~last_q[b];
    end
  end

  always_ff @(posedge clock_i) last_q <= pin_o;
endmodule

`default_nettype wire

// File: rsc_tb.sv
// Purpose: Self-checking bench for the reset strap capture block.
// Assumes: Watchdog limit shortened to 20 cycles.
// Notes:   Eight strap patterns, each under its own reset.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb;
  import rsc_pkg::*;
  localparam int WD = 20;
  logic              clock_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [17:0]       strap_low = '0;
  logic [3:0]        txen = '0, txerr = '0;
  logic              top_a = 1'b0, top_b = 1'b0;
  logic [8:0]        cpu = '0;
  logic [15:0]       led_bits = '0;
  logic              led_sd = 1'b0, env_n = 1'b1, busy = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rd_v;
  logic              wr = 1'b0, rd = 1'b0;
  wire  [DATA_W-1:0] rdata;
  wire  [17:0]       pins, drv, oe;
  wire  [13:0]       dec;
  wire  [7:0]        pmode;
  wire  [1:0]        fsize;
  wire  [2:0]        fdly, ddly;
  wire               pull_en, wd_rst, cfg_v;
  int                mismatches = 0;
  int                n_compared = 0;

  always #5 clock_i = ~clock_i;

  rsc_strap_board i_board (
    .clock_i(clock_i), .strap_low_i(strap_low), .drv_i(drv), .oe_i(oe),
    .pullup_en_i(pull_en), .pin_o(pins));

  rsc_strap_capture #(.WD_LIMIT(WD)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .strap_pin_i(pins[15:0]), .strap_pin_o(drv[15:0]), .strap_pin_oe_o(oe[15:0]),
    .strap_pullup_en_o(pull_en),
    .blink_pin_i(pins[16]), .blink_pin_o(drv[16]), .blink_pin_oe_o(oe[16]),
    .led_iface_select_strap_i(pins[17]), .serial_led_envelope_n_o(drv[17]),
    .envelope_pin_oe_o(oe[17]),
    .port_txen_strap_i(txen), .port_txerr_strap_i(txerr),
    .frame_bank_top_addr_i(top_a), .second_bank_top_addr_i(top_b),
    .cpu_data_pin_i(cpu), .parallel_led_bits_i(led_bits),
    .serial_led_data_i(led_sd), .serial_led_envelope_n_i(env_n),
    .sm_busy_i(busy), .wd_reset_o(wd_rst), .cfg_valid_o(cfg_v), .port_mode_o(pmode),
    .led_blink_en_o(dec[13]), .led_parallel_o(dec[12]), .link_active_high_o(dec[11]),
    .power_save_en_o(dec[10]), .module_detect_en_o(dec[9]), .db_sram_256k_o(dec[8]),
    .cpu_bus_16bit_o(dec[7]), .frame_single_layer_o(dec[6]), .frame_mem_size_o(fsize),
    .eeprom_present_o(dec[5]), .mct_aging_en_o(dec[4]), .fcb_aging_en_o(dec[3]),
    .timeout_reset_en_o(dec[2]), .cpu_present_o(dec[1]), .mem_selftest_loop_o(dec[0]),
    .frame_clk_delay_o(fdly), .db_clk_delay_o(ddly),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] ex);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 rd_v = rdata;
    `CHK(nm, ex, rd_v)
  endtask

  task automatic run_pattern(input logic [2:0] i);
    logic [15:0] w;
    logic [15:0] low;
    logic [7:0]  pm;
    logic [1:0]  c;
    logic [13:0] ed;
    logic [2:0]  ef, eb;
    int          n;
    low = i[0] ? 16'h3c6a : 16'hc395;
    w = ~(low | 16'h0014);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    busy <= 1'b0;
    strap_low <= {i[2], i[1], low};
    cpu <= {~i, 3'b101, i};
    top_a <= i[1];
    top_b <= i[0];
    for (int p = 0; p < 4; p++) begin
      c = 2'(i + p);
      txen[p] <= c[1];
      txerr[p] <= c[0];
      pm[2*p+:2] = c;
    end
    repeat (9) @(posedge clock_i);
    #1;
    `CHK("oe_in_reset", 18'h00000, oe)
    `CHK("pullup_in_reset", 1'b1, pull_en)
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    ed = {i[1], ~i[2], w[0], w[1], ~w[3], w[5], w[6], w[7], ~w[8], w[9], w[10], w[11],
          ~w[14], ~w[15]};
    `CHK("cfg_valid", 1'b1, cfg_v)
    `CHK("oe_after_reset", 18'h3ffff, oe)
    `CHK("pullup_after_reset", 1'b0, pull_en)
    `CHK("decoded", ed, dec)
    `CHK("port_mode", pm, pmode)
    `CHK("frame_size", i[1] ? (i[0] ? FSZ_2M : FSZ_1M) : FSZ_512K, fsize)
    // Pins move after capture; the latched view must not follow
    @(posedge clock_i);
    strap_low <= ~strap_low;
    cpu <= ~cpu;
    txen <= ~txen;
    txerr <= ~txerr;
    top_a <= ~top_a;
    reg_wr(OFS_FRAME_CLK_DLY, 16'hfffd);
    reg_wr(OFS_DB_CLK_DLY, 16'hfffe);
    reg_wr(OFS_STRAP_WORD, 16'h0000);
    repeat (2) @(posedge clock_i);
    #1;
    ef = (i == 3'h0) ? 3'h5 : i - 3'h1;
    eb = (i == 3'h7) ? 3'h6 : 3'h6 - i;
    `CHK("frame_delay", ef, fdly)
    `CHK("db_delay", eb, ddly)
    `CHK("port_mode_held", pm, pmode)
    `CHK("decoded_held", ed, dec)
    rd_chk("status01", OFS_STATUS_P01, {8'h00, 1'b1, 3'h0, pm[3:0]});
    rd_chk("status23", OFS_STATUS_P23, {8'h00, 1'b1, 3'h0, pm[7:4]});
    rd_chk("strap_word", OFS_STRAP_WORD, w);
    rd_chk("cpu_straps", OFS_CPU_STRAP, {7'h00, ~i, 3'b101, i});
    rd_chk("frame_dly_reg", OFS_FRAME_CLK_DLY, 16'h0005);
    rd_chk("db_dly_reg", OFS_DB_CLK_DLY, 16'h0006);
    rd_chk("unmapped", 4'hf, 16'h0000);
    @(posedge clock_i);
    led_bits <= w ^ 16'h5a3c;
    led_sd <= ~i[0];
    env_n <= i[0];
    @(posedge clock_i);
    #1;
    `CHK("led_pins", {i[0], ~i[0], w ^ 16'h5a3c}, pins)
    @(posedge clock_i);
    busy <= 1'b1;
    n = 0;
    while (n < 3 * WD && wd_rst !== 1'b1) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK("wd_pulse_time", w[11], (n >= WD - 1 && n <= WD + 2))
    @(posedge clock_i);
    #1;
    `CHK("wd_pulse_len", 1'b0, wd_rst)
  endtask

  initial begin
    for (int k = 0; k < 8; k++) begin
      run_pattern(3'(k));
    end
    print_verdict();
  end

  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule

`default_nettype wire
